// >>> seq_cfg.svh
// constants for the program sequencer and table read logic
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH
`define PC_WIDTH 15
`define PHASES_PER_CYCLE 4
`define PHASE_WIDTH 2
`define VEC_RESET 15'h0000
`define VEC_IRQ_A 15'h0004
`define VEC_IRQ_B 15'h0008
`define VEC_TIMER0 15'h000c
`define VEC_TIMER1 15'h0010
`define VEC_SERIAL 15'h0014
`define VEC_MULTI 15'h0018
`define IRQ_COUNT 6
`define ADDR_PC_LOW 8'h06
`define ADDR_TABLE_PTR_LOW 8'h07
`define ADDR_TABLE_HIGH_LATCH 8'h08
`define ADDR_TABLE_PAGE_PTR 8'h1f
`define ADDR_BANK_SELECT 8'h04
`define BANK_LSB 5
`define BANK_MSB 6
`define JUMP_WIDTH 13
`define LAST_PAGE 7'h7f
`define RESET_BYTE 8'h00
`endif

// >>> seq_pkg.sv
// types shared by the program sequencer modules
package seq_pkg;
  typedef enum logic [2:0]
  {
    op_next = 3'h0,
    op_skip = 3'h1,
    op_jump = 3'h3,
    op_return = 3'h2,
    op_table_current = 3'h6,
    op_table_last = 3'h7
  } op_type;
  typedef enum logic [1:0]
  {
    st_run = 2'h0,
    st_dummy = 2'h1,
    st_table = 2'h3
  } state_type;
endpackage : seq_pkg

// >>> irq_if.sv
// interrupt request and grant signals between arbiter and sequencer
`timescale 1ns/1ns
interface irq_if;
  logic [5:0] pending;
  logic grant_valid;
  logic [14:0] grant_vector;
  logic [5:0] grant_onehot;
  modport arb (input pending, output grant_valid, output grant_vector,
    output grant_onehot);
  modport seq (output pending, input grant_valid, input grant_vector,
    input grant_onehot);
endinterface : irq_if

// >>> irq_arbiter.sv
// fixed priority interrupt arbiter, lowest vector wins
`timescale 1ns/1ns
`include "seq_cfg.svh"
module irq_arbiter
(
  irq_if.arb irq
);
  always_comb
  begin
    irq.grant_valid = 1'b0;
    irq.grant_vector = `VEC_RESET;
    irq.grant_onehot = 6'h00;
    if (irq.pending[0])
    begin
      irq.grant_valid = 1'b1; // RULE_23
      irq.grant_vector = `VEC_IRQ_A;
      irq.grant_onehot = 6'h01;
    end
    else if (irq.pending[1])
    begin
      irq.grant_valid = 1'b1;
      irq.grant_vector = `VEC_IRQ_B;
      irq.grant_onehot = 6'h02;
    end
    else if (irq.pending[2])
    begin
      irq.grant_valid = 1'b1;
      irq.grant_vector = `VEC_TIMER0;
      irq.grant_onehot = 6'h04;
    end
    else if (irq.pending[3])
    begin
      irq.grant_valid = 1'b1;
      irq.grant_vector = `VEC_TIMER1;
      irq.grant_onehot = 6'h08;
    end
    else if (irq.pending[4])
    begin
      irq.grant_valid = 1'b1;
      irq.grant_vector = `VEC_SERIAL;
      irq.grant_onehot = 6'h10;
    end
    else if (irq.pending[5])
    begin
      irq.grant_valid = 1'b1;
      irq.grant_vector = `VEC_MULTI;
      irq.grant_onehot = 6'h20;
    end
  end
endmodule : irq_arbiter

// >>> program_sequencer_table_read.sv
// program counter, bank selection, vectoring and table reads
`timescale 1ns/1ns
`include "seq_cfg.svh"
// Overview of operation
// [RULE_01] a true skip discards the prefetched word and runs a dummy cycle
// [RULE_02] pc low byte is read/write; writing jumps in-page with a dummy
// [RULE_03] top counter bit comes from bank select bit 5; the code takes bit 14 from bank bit 6 and bit 13 from bank bit 5
// [RULE_04] program memory is 32768 words of 16 bits, by pc or table pointer
// [RULE_05] banks hold 8192 words, chosen by bank select bits 5 and 6
// [RULE_06] software sets bank bits before 13-bit jumps and calls
// [RULE_07] returns restore the full counter, bank bits included
// [RULE_08] reset loads the counter with address zero
// [RULE_09] vector 004h for external request a or conversion done
// [RULE_10] vector 008h for external request b or serial transfer done
// [RULE_11] timer 0 overflow vectors to 00ch
// [RULE_12] timer 1 overflow vectors to 010h
// [RULE_13] uart or serial completion vectors to 014h
// [RULE_14] multi-function sources vector to 018h
// [RULE_15] current-page table read uses page pointer over pointer low byte
// [RULE_16] last-page table read forces bits 14..8 to ones
// [RULE_17] table read low byte to data memory, rest to high latch
// [RULE_18] table reads take two instruction cycles
// [RULE_19] software loads both table pointers before a table read
// [RULE_20] an instruction cycle is four clocks, fetch overlaps execute
// [RULE_21] counter steps by one per fetch; changing it costs two cycles
// [RULE_22] full stack holds enabled requests unacknowledged until a return
// [RULE_23] simultaneous requests are served lowest vector first
module program_sequencer_table_read
#(
  parameter bit SRC_A_IS_ADC = 1'b0,
  parameter bit SRC_B_IS_SERIAL = 1'b0,
  parameter bit SRC_E_IS_SERIAL = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] op_code,
  input wire logic op_valid,
  input wire logic skip_true,
  input wire logic [12:0] jump_target,
  input wire logic [14:0] return_addr,
  input wire logic stack_full,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  input wire logic adc_done,
  input wire logic spi_done,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  input wire logic uart_done,
  input wire logic multi_event,
  input wire logic [5:0] irq_enable,
  input wire logic [15:0] rom_data,
  output logic [14:0] rom_addr,
  output logic fetch_strobe,
  output logic cycle_end,
  output logic discard_fetch,
  output logic irq_ack,
  output logic [5:0] irq_ack_line,
  output logic [14:0] push_addr,
  output logic [7:0] table_low_data,
  output logic table_low_write
);
  localparam logic [1:0] last_phase = 2'(`PHASES_PER_CYCLE - 1);
  logic [1:0] phase_reg;
  seq_pkg::state_type state_reg;
  logic [14:0] pc_reg;
  logic [7:0] bank_select_reg;
  logic [7:0] table_ptr_low_reg;
  logic [7:0] table_page_ptr_reg;
  logic [7:0] table_high_latch_reg;
  logic [5:0] pending_reg;
  logic [1:0] irq_raw_reg;
  logic [1:0] irq_sync_reg;
  logic [1:0] irq_prev_reg;
  logic [5:0] src_now;
  logic cycle_done;
  logic irq_take;
  logic pcl_write;
  logic [14:0] table_addr;
  logic table_last_reg;
  irq_if irq ();

  irq_arbiter arbiter
  (
    .irq(irq)
  );

  // bank bits form the top two address bits of a 13-bit jump
  function automatic logic [14:0] bank_addr(input logic [7:0] bank,
    input logic [12:0] low);
    bank_addr = {bank[`BANK_MSB], bank[`BANK_LSB], low}; // RULE_03 RULE_05
  endfunction : bank_addr

  assign cycle_done = (phase_reg == last_phase);
  assign pcl_write = reg_write && (reg_addr == `ADDR_PC_LOW);
  assign irq_take = cycle_done && (state_reg == seq_pkg::st_run)
    && irq.grant_valid && !stack_full; // RULE_22
  assign table_addr = table_last_reg
    ? {`LAST_PAGE, table_ptr_low_reg} // RULE_16
    : {table_page_ptr_reg[6:0], table_ptr_low_reg}; // RULE_15

  // the op code is free to change once taken, so the table kind is kept
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      table_last_reg <= 1'b0;
    else if (cycle_done && state_reg == seq_pkg::st_run)
      table_last_reg <= (op_code == seq_pkg::op_table_last); // RULE_16
  end

  // external pins pass two flops before edge detection
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_raw_reg <= 2'h0;
      irq_sync_reg <= 2'h0;
      irq_prev_reg <= 2'h0;
    end
    else
    begin
      irq_raw_reg <= {ext_irq_b, ext_irq_a};
      irq_sync_reg <= irq_raw_reg;
      irq_prev_reg <= irq_sync_reg;
    end
  end

  always_comb
  begin
    src_now[0] = SRC_A_IS_ADC ? adc_done
      : (irq_sync_reg[0] && !irq_prev_reg[0]); // RULE_09
    src_now[1] = SRC_B_IS_SERIAL ? spi_done
      : (irq_sync_reg[1] && !irq_prev_reg[1]); // RULE_10
    src_now[2] = timer0_ovf; // RULE_11
    src_now[3] = timer1_ovf; // RULE_12
    src_now[4] = SRC_E_IS_SERIAL ? spi_done : uart_done; // RULE_13
    src_now[5] = multi_event; // RULE_14
  end

  assign irq.pending = pending_reg & irq_enable;

  // a new event in the grant cycle is kept: set wins over clear
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pending_reg <= 6'h00;
    else if (irq_take)
      pending_reg <= (pending_reg & ~irq.grant_onehot) | src_now;
    else
      pending_reg <= pending_reg | src_now; // RULE_22
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1; // RULE_20
  end

  // sequencer state: dummy and table cycles are the second of two
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state_reg <= seq_pkg::st_run;
    else if (cycle_done)
    begin
      case (state_reg)
        seq_pkg::st_run:
        begin
          if (irq_take)
            state_reg <= seq_pkg::st_dummy;
          else if (pcl_write)
            state_reg <= seq_pkg::st_dummy; // RULE_02
          else if (op_valid && op_code == seq_pkg::op_skip && skip_true)
            state_reg <= seq_pkg::st_dummy; // RULE_01
          else if (op_valid && (op_code == seq_pkg::op_jump
            || op_code == seq_pkg::op_return))
            state_reg <= seq_pkg::st_dummy; // RULE_21
          else if (op_valid && (op_code == seq_pkg::op_table_current
            || op_code == seq_pkg::op_table_last))
            state_reg <= seq_pkg::st_table; // RULE_18
        end
        default:
          state_reg <= seq_pkg::st_run;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      pc_reg <= `VEC_RESET; // RULE_08
    else if (cycle_done)
    begin
      if (irq_take)
        pc_reg <= irq.grant_vector;
      else if (state_reg == seq_pkg::st_table)
        pc_reg <= pc_reg;
      else if (state_reg == seq_pkg::st_dummy)
        pc_reg <= pc_reg + 15'h0001; // RULE_21
      else if (pcl_write)
        pc_reg <= {pc_reg[14:8], reg_wdata}; // RULE_02
      else if (op_valid && op_code == seq_pkg::op_jump)
        pc_reg <= bank_addr(bank_select_reg, jump_target); // RULE_06
      else if (op_valid && op_code == seq_pkg::op_return)
        pc_reg <= return_addr; // RULE_07
      else if (op_valid && (op_code == seq_pkg::op_table_current
        || op_code == seq_pkg::op_table_last))
        pc_reg <= pc_reg;
      else
        pc_reg <= pc_reg + 15'h0001; // RULE_21
    end
  end

  // skip advances past the discarded word during the dummy cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      discard_fetch <= 1'b0;
    else if (cycle_done)
      discard_fetch <= (state_reg == seq_pkg::st_run) && !irq_take
        && (pcl_write || (op_valid && op_code != seq_pkg::op_next
        && !(op_code == seq_pkg::op_skip && !skip_true))); // RULE_01
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      bank_select_reg <= `RESET_BYTE;
      table_ptr_low_reg <= `RESET_BYTE;
      table_page_ptr_reg <= `RESET_BYTE;
    end
    else if (reg_write)
    begin
      if (reg_addr == `ADDR_BANK_SELECT)
        bank_select_reg <= reg_wdata;
      else if (reg_addr == `ADDR_TABLE_PTR_LOW)
        table_ptr_low_reg <= reg_wdata; // RULE_19
      else if (reg_addr == `ADDR_TABLE_PAGE_PTR)
        table_page_ptr_reg <= reg_wdata;
    end
  end

  // table word lands at the end of the second cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      table_high_latch_reg <= `RESET_BYTE;
      table_low_data <= `RESET_BYTE;
      table_low_write <= 1'b0;
    end
    else
    begin
      table_low_write <= cycle_done && state_reg == seq_pkg::st_table;
      if (cycle_done && state_reg == seq_pkg::st_table)
      begin
        table_low_data <= rom_data[7:0]; // RULE_17
        table_high_latch_reg <= rom_data[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= `RESET_BYTE;
    else if (reg_read)
    begin
      if (reg_addr == `ADDR_PC_LOW)
        reg_rdata <= pc_reg[7:0]; // RULE_02
      else if (reg_addr == `ADDR_BANK_SELECT)
        reg_rdata <= bank_select_reg;
      else if (reg_addr == `ADDR_TABLE_PTR_LOW)
        reg_rdata <= table_ptr_low_reg;
      else if (reg_addr == `ADDR_TABLE_HIGH_LATCH)
        reg_rdata <= table_high_latch_reg;
      else if (reg_addr == `ADDR_TABLE_PAGE_PTR)
        reg_rdata <= table_page_ptr_reg;
      else
        reg_rdata <= `RESET_BYTE;
    end
  end

  // rom address switches to the table word only inside the table cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rom_addr <= `VEC_RESET;
      fetch_strobe <= 1'b0;
      cycle_end <= 1'b0;
      irq_ack <= 1'b0;
      irq_ack_line <= 6'h00;
      push_addr <= `VEC_RESET;
    end
    else
    begin
      fetch_strobe <= (phase_reg == 2'h0); // RULE_04
      cycle_end <= cycle_done;
      irq_ack <= irq_take;
      irq_ack_line <= irq_take ? irq.grant_onehot : 6'h00;
      if (irq_take)
        push_addr <= pc_reg;
      if (state_reg == seq_pkg::st_table)
        rom_addr <= table_addr; // RULE_04
      else
        rom_addr <= pc_reg;
    end
  end

  sequence s_table_start;
    cycle_done && state_reg == seq_pkg::st_run && !irq_take && !pcl_write
      && op_valid && (op_code == seq_pkg::op_table_current
      || op_code == seq_pkg::op_table_last);
  endsequence

  property p_table_two_cycles;
    @(posedge ref_clk) disable iff (reset)
    s_table_start |=> ##3 (state_reg == seq_pkg::st_table) ##1
      table_low_write;
  endproperty
  a_table_two_cycles: assert property (p_table_two_cycles) // RULE_18
    else $error("table read did not finish in two cycles");

  property p_reset_zero;
    @(posedge ref_clk) $fell(reset) |-> pc_reg == `VEC_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // RULE_08
    else $error("counter not zero after reset");

  property p_phase_wrap;
    @(posedge ref_clk) disable iff (reset)
    cycle_done |=> !cycle_done [*3] ##1 cycle_done;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) // RULE_20
    else $error("instruction cycle not four clocks");

  property p_stack_full_hold;
    @(posedge ref_clk) disable iff (reset)
    stack_full |=> !irq_ack;
  endproperty
  a_stack_full_hold: assert property (p_stack_full_hold) // RULE_22
    else $error("request taken with full stack");

  property p_pcl_jump;
    @(posedge ref_clk) disable iff (reset)
    (cycle_done && state_reg == seq_pkg::st_run && !irq_take && pcl_write)
      |=> pc_reg == {$past(pc_reg[14:8]), $past(reg_wdata)}
      && state_reg == seq_pkg::st_dummy;
  endproperty
  a_pcl_jump: assert property (p_pcl_jump) // RULE_02
    else $error("low byte write jump wrong");

  property p_jump_bank;
    @(posedge ref_clk) disable iff (reset)
    (cycle_done && state_reg == seq_pkg::st_run && !irq_take && !pcl_write
      && op_valid && op_code == seq_pkg::op_jump)
      |=> pc_reg[14:13] == {$past(bank_select_reg[6]),
      $past(bank_select_reg[5])};
  endproperty
  a_jump_bank: assert property (p_jump_bank) // RULE_03
    else $error("jump bank bits wrong");

  property p_skip_dummy;
    @(posedge ref_clk) disable iff (reset)
    (cycle_done && state_reg == seq_pkg::st_run && !irq_take && !pcl_write
      && op_valid && op_code == seq_pkg::op_skip && skip_true)
      |=> discard_fetch && pc_reg == $past(pc_reg) + 15'h0001;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy) // RULE_01
    else $error("skip did not discard");

  property p_priority;
    @(posedge ref_clk) disable iff (reset)
    (irq_take && irq.pending[0]) |=> pc_reg == `VEC_IRQ_A && irq_ack;
  endproperty
  a_priority: assert property (p_priority) // RULE_23
    else $error("lowest vector not served first");

  property p_last_page;
    @(posedge ref_clk) disable iff (reset)
    (cycle_done && state_reg == seq_pkg::st_run && !irq_take && !pcl_write
      && op_valid && op_code == seq_pkg::op_table_last)
      |=> ##2 (rom_addr[14:8] == `LAST_PAGE) [*2];
  endproperty
  a_last_page: assert property (p_last_page) // RULE_16
    else $error("last page address wrong");
endmodule : program_sequencer_table_read

// >>> rom_model.sv
// program memory model answering fetches and table reads
`timescale 1ns/1ns
module rom_model
(
  input wire logic [14:0] rom_addr,
  output logic [15:0] rom_data
);
  // 32768 words of 16 bits; contents are a fixed function of the address
  // so that a wrong table address shows up as wrong data
  assign rom_data = {rom_addr[14:7], rom_addr[7:0] ^ 8'h5a};
endmodule : rom_model

// >>> testbench.sv
// self-checking bench for the program sequencer and table reads
`timescale 1ns/1ns
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] op_code = 3'h0;
  logic skip_true = 1'b0;
  logic [12:0] jump_target = 13'h0000;
  logic [14:0] return_addr = 15'h0000;
  logic stack_full = 1'b0;
  logic [5:0] src = 6'h00;
  logic [5:0] irq_enable = 6'h3f;
  logic [15:0] rom_data;
  logic [14:0] rom_addr;
  logic fetch_strobe, cycle_end, discard_fetch, irq_ack, table_low_write;
  logic [5:0] irq_ack_line;
  logic [14:0] push_addr;
  logic [7:0] table_low_data;
  logic rd_pend = 1'b0;
  logic op_valid = 1'b1;
  logic [14:0] last_fetch = 15'h0000;
  logic [7:0] rd_q[$];
  logic [7:0] tab_q[$];
  logic [7:0] ack_q[$];
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] v;
  logic [7:0] ptr;
  logic [15:0] w;
  logic [14:0] a;
  always #5 ref_clk = ~ref_clk;
  program_sequencer_table_read dut_u (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .op_code(op_code),
    .op_valid(op_valid), .skip_true(skip_true), .jump_target(jump_target),
    .return_addr(return_addr), .stack_full(stack_full),
    .ext_irq_a(src[0]), .ext_irq_b(src[1]), .adc_done(1'b0),
    .spi_done(1'b0), .timer0_ovf(src[2]), .timer1_ovf(src[3]),
    .uart_done(src[4]), .multi_event(src[5]), .irq_enable(irq_enable),
    .rom_data(rom_data), .rom_addr(rom_addr), .fetch_strobe(fetch_strobe),
    .cycle_end(cycle_end), .discard_fetch(discard_fetch),
    .irq_ack(irq_ack), .irq_ack_line(irq_ack_line), .push_addr(push_addr),
    .table_low_data(table_low_data), .table_low_write(table_low_write));
  rom_model mem_u (.rom_addr(rom_addr), .rom_data(rom_data));
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic cmp_byte(input string n, input logic [7:0] e,
    input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : cmp_byte
  task automatic cmp_addr(input string n, input logic [14:0] e,
    input logic [14:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : cmp_addr
  task automatic timed_out(input string n);
    $display("mismatch %s expected event seen timeout", n);
    error_cnt++;
    give_verdict();
  endtask : timed_out
  task automatic pop_cmp(ref logic [7:0] q[$], input logic [7:0] g,
    input string n);
    if (q.size() == 0)
    begin
      $display("mismatch %s expected none seen %h", n, g);
      error_cnt++;
    end
    else
      cmp_byte(n, q.pop_front(), g);
  endtask : pop_cmp
  // the watcher takes the oldest note whenever a result appears
  always @(posedge ref_clk) rd_pend <= reg_read;
  always @(negedge ref_clk)
  begin
    if (rd_pend)
      pop_cmp(rd_q, reg_rdata, "reg_rdata");
    if (table_low_write === 1'b1)
      pop_cmp(tab_q, table_low_data, "table_low_data");
    if (irq_ack === 1'b1)
    begin
      pop_cmp(ack_q, {2'h0, irq_ack_line}, "irq_ack_line");
      // the word fetched in the grant cycle is dropped, so it is the return
      cmp_addr("push_addr", last_fetch, push_addr);
    end
    if (fetch_strobe === 1'b1)
      last_fetch = rom_addr;
  end
  function automatic logic [15:0] rom_word(input logic [14:0] x);
    return {x[14:7], x[7:0] ^ 8'h5a};
  endfunction : rom_word
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= ad;
    rd_q.push_back(e);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask : rd
  task automatic wait_ce;
    int n;
    for (n = 0; n < 16; n++)
    begin
      @(negedge ref_clk);
      if (cycle_end === 1'b1)
        break;
    end
    if (n == 16)
      timed_out("cycle_end");
  endtask : wait_ce
  // ops are levels taken at the phase-3 edge, so hold one full cycle
  task automatic do_op(input logic [2:0] c);
    wait_ce();
    @(posedge ref_clk);
    op_code <= c;
    wait_ce();
    @(posedge ref_clk);
    op_code <= seq_pkg::op_next;
  endtask : do_op
  task automatic find_fetch(input logic [14:0] x);
    int n;
    for (n = 0; n < 60; n++)
    begin
      @(negedge ref_clk);
      if (fetch_strobe === 1'b1 && rom_addr === x)
        break;
    end
    if (n == 60)
      timed_out("fetch address");
    check_count++;
    for (n = 0; n < 16; n++)
    begin
      @(negedge ref_clk);
      if (fetch_strobe === 1'b1)
        break;
    end
    cmp_addr("next fetch", x + 15'h0001, rom_addr);
  endtask : find_fetch
  initial
  begin
    v = $urandom(23);
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    find_fetch(15'h0000);
    rd(8'h08, 8'h00);
    rd(8'h30, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      ptr = $urandom;
      v = $urandom;
      wr(8'h07, ptr);
      wr(8'h1f, v);
      rd(8'h07, ptr);
      rd(8'h1f, v);
      a = k ? {7'h7f, ptr} : {v[6:0], ptr};
      w = rom_word(a);
      tab_q.push_back(w[7:0]);
      do_op(k ? seq_pkg::op_table_last : seq_pkg::op_table_current);
      // the word must be delivered within six clocks after the two instruction cycles end
      wait_ce();
      repeat (6) @(posedge ref_clk);
      cmp_byte("table queue", 8'h00, 8'(tab_q.size()));
      rd(8'h08, w[15:8]);
      wr(8'h08, ~w[15:8]);
      rd(8'h08, w[15:8]);
    end
    for (int k = 0; k < 4; k++)
    begin
      v = 8'(k << 5) | 8'($urandom & 32'h9f);
      wr(8'h04, v);
      rd(8'h04, v);
      jump_target <= 13'($urandom);
      do_op(seq_pkg::op_jump);
      find_fetch({v[6:5], jump_target});
    end
    // a low byte write lands only at the end of an instruction cycle
    jump_target <= {5'($urandom), 8'h10};
    do_op(seq_pkg::op_jump);
    find_fetch({v[6:5], jump_target});
    wait_ce();
    repeat (2) @(posedge ref_clk);
    wr(8'h06, ptr);
    find_fetch({v[6:5], jump_target[12:8], ptr});
    rd(8'h06, ptr + 8'h01);
    skip_true <= 1'b1;
    do_op(seq_pkg::op_skip);
    v = 8'h00;
    for (int n = 0; n < 12; n++)
    begin
      @(negedge ref_clk);
      if (discard_fetch === 1'b1)
        v = 8'h01;
    end
    cmp_byte("discard_fetch", 8'h01, v);
    op_valid <= 1'b0;
    do_op(seq_pkg::op_jump);
    v = 8'h00;
    for (int n = 0; n < 12; n++)
    begin
      @(negedge ref_clk);
      if (discard_fetch === 1'b1)
        v = 8'h01;
    end
    cmp_byte("invalid op discard", 8'h00, v);
    op_valid <= 1'b1;
    return_addr <= 15'h4000 | 15'($urandom);
    do_op(seq_pkg::op_return);
    find_fetch(return_addr);
    for (int i = 0; i < 6; i++)
    begin
      ack_q.push_back(8'(1 << i));
      @(posedge ref_clk);
      src <= 6'(1 << i);
      @(posedge ref_clk);
      src <= 6'h00;
      find_fetch(15'(4 * (i + 1)));
    end
    ack_q.push_back(8'h04);
    ack_q.push_back(8'h08);
    @(posedge ref_clk);
    src <= 6'h0c;
    @(posedge ref_clk);
    src <= 6'h00;
    find_fetch(15'h000c);
    find_fetch(15'h0010);
    // a masked request stays latched and is served once enabled
    irq_enable <= 6'h3b;
    @(posedge ref_clk);
    src <= 6'h04;
    @(posedge ref_clk);
    src <= 6'h00;
    repeat (24) @(posedge ref_clk);
    ack_q.push_back(8'h04);
    irq_enable <= 6'h3f;
    find_fetch(15'h000c);
    stack_full <= 1'b1;
    @(posedge ref_clk);
    src <= 6'h10;
    @(posedge ref_clk);
    src <= 6'h00;
    // an acknowledge here finds the queue empty and is counted
    repeat (40) @(posedge ref_clk);
    ack_q.push_back(8'h10);
    stack_full <= 1'b0;
    find_fetch(15'h0014);
    repeat (8) @(posedge ref_clk);
    cmp_byte("ack queue", 8'h00, 8'(ack_q.size()));
    give_verdict();
  end
endmodule : testbench
